// file: crc_conv_regs.vh
// Register offsets, field positions, reset values and timing figures of the rate config block
`ifndef CRC_CONV_REGS_VH
`define CRC_CONV_REGS_VH

// Register byte addresses
`define CRC_ADDR_CONFIG 8'h00
`define CRC_ADDR_EXC 8'h04
`define CRC_ADDR_STATUS 8'h08
`define CRC_ADDR_CAPTIME 8'h0c
`define CRC_ADDR_VTTIME 8'h10

// Reset values
`define CRC_CONFIG_RST 8'ha0
`define CRC_EXC_RST 8'h03

// Field positions in the configuration register
`define CRC_VTF_HI 7
`define CRC_VTF_LO 6
`define CRC_CAPF_HI 5
`define CRC_CAPF_LO 3
`define CRC_MODE_HI 2
`define CRC_MODE_LO 0
// Field position in the excitation setup register
`define CRC_CLK_HALVE 7

// Conversion mode codes
`define CRC_MODE_IDLE 3'h0
`define CRC_MODE_CONT 3'h1
`define CRC_MODE_SINGLE 3'h2
`define CRC_MODE_PDOWN 3'h3
`define CRC_MODE_OFFCAL 3'h5
`define CRC_MODE_GAINCAL 3'h6

// Clock rate in kHz, so that cycles = microseconds * kHz / 1000
`define CRC_SYS_CLK_KHZ 25000

// Voltage/temperature conversion times in microseconds
`define CRC_VT_T0_US 20100
`define CRC_VT_T1_US 32100
`define CRC_VT_T2_US 62100
`define CRC_VT_T3_US 122100

// Capacitance conversion times in microseconds
`define CRC_CAP_T0_US 11000
`define CRC_CAP_T1_US 11900
`define CRC_CAP_T2_US 20000
`define CRC_CAP_T3_US 38000
`define CRC_CAP_T4_US 62000
`define CRC_CAP_T5_US 77000
`define CRC_CAP_T6_US 92000
`define CRC_CAP_T7_US 109600

`endif

// file: crc_conversion_rate_config.v
// Conversion rate configuration, conversion timer and APB register slave
// What this block does
// - Voltage/temperature filter code 00..11 gives 20.1, 32.1, 62.1, 122.1 ms conversions.
// - Capacitance filter code 000..101 gives 11.0, 11.9, 20.0, 38.0, 62.0, 77.0 ms.
// - Those tabulated times hold while the clock halving bit is zero.
// - Clock halving bit set doubles every conversion time on both channels.
`include "crc_conv_regs.vh"

module crc_conversion_rate_config #(
  parameter VT_CYC0 = `CRC_VT_T0_US * (`CRC_SYS_CLK_KHZ / 1000),
  parameter VT_CYC1 = `CRC_VT_T1_US * (`CRC_SYS_CLK_KHZ / 1000),
  parameter VT_CYC2 = `CRC_VT_T2_US * (`CRC_SYS_CLK_KHZ / 1000),
  parameter VT_CYC3 = `CRC_VT_T3_US * (`CRC_SYS_CLK_KHZ / 1000),
  parameter CAP_CYC0 = `CRC_CAP_T0_US * (`CRC_SYS_CLK_KHZ / 1000),
  parameter CAP_CYC1 = `CRC_CAP_T1_US * (`CRC_SYS_CLK_KHZ / 1000),
  parameter CAP_CYC2 = `CRC_CAP_T2_US * (`CRC_SYS_CLK_KHZ / 1000),
  parameter CAP_CYC3 = `CRC_CAP_T3_US * (`CRC_SYS_CLK_KHZ / 1000),
  parameter CAP_CYC4 = `CRC_CAP_T4_US * (`CRC_SYS_CLK_KHZ / 1000),
  parameter CAP_CYC5 = `CRC_CAP_T5_US * (`CRC_SYS_CLK_KHZ / 1000),
  parameter CAP_CYC6 = `CRC_CAP_T6_US * (`CRC_SYS_CLK_KHZ / 1000),
  parameter CAP_CYC7 = `CRC_CAP_T7_US * (`CRC_SYS_CLK_KHZ / 1000)
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Converter timing
  output reg capConverting,
  output reg vtConverting,
  output reg capDone,
  output reg vtDone,
  output reg [23:0] capConvCycles,
  output reg [23:0] vtConvCycles
);

  localparam ST_IDLE = 2'd0;
  localparam ST_CAP = 2'd1;
  localparam ST_VT = 2'd2;

  // Tabulated value with halving off, twice it with halving on; both channels share it
  function [23:0] scaleTime;
    input [23:0] base;
    input halve;
    begin
      // The top bit is dropped, so tabulated counts must stay below half the counter range
      scaleTime = halve ? {base[22:0], 1'b0} : base;
    end
  endfunction

  // Modes that run the capacitance then voltage/temperature pair
  function modeRuns;
    input [2:0] mode;
    begin
      case (mode)
        `CRC_MODE_CONT: modeRuns = 1'b1;
        `CRC_MODE_SINGLE: modeRuns = 1'b1;
        default: modeRuns = 1'b0;
      endcase
    end
  endfunction

  // Calibration modes run one capacitance conversion only
  function modeCalibrates;
    input [2:0] mode;
    begin
      case (mode)
        `CRC_MODE_OFFCAL: modeCalibrates = 1'b1;
        `CRC_MODE_GAINCAL: modeCalibrates = 1'b1;
        default: modeCalibrates = 1'b0;
      endcase
    end
  endfunction

  // Address match for a register offset
  function regHit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      regHit = (addr == offset);
    end
  endfunction

  // Config value with the mode field put back to idle, other fields kept
  function [7:0] withModeIdle;
    input [7:0] cfg;
    reg [7:0] result;
    begin
      result = cfg;
      result[`CRC_MODE_HI:`CRC_MODE_LO] = `CRC_MODE_IDLE;
      withModeIdle = result;
    end
  endfunction

  // Conversion time in cycles for a voltage/temperature filter code
  function [23:0] vtCycles;
    input [1:0] code;
    input halve;
    reg [23:0] base;
    begin
      case (code)
        2'h0: base = VT_CYC0[23:0];
        2'h1: base = VT_CYC1[23:0];
        2'h2: base = VT_CYC2[23:0];
        default: base = VT_CYC3[23:0];
      endcase
      vtCycles = scaleTime(base, halve);
    end
  endfunction

  // Conversion time in cycles for a capacitance filter code
  function [23:0] capCycles;
    input [2:0] code;
    input halve;
    reg [23:0] base;
    begin
      case (code)
        3'h0: base = CAP_CYC0[23:0];
        3'h1: base = CAP_CYC1[23:0];
        3'h2: base = CAP_CYC2[23:0];
        3'h3: base = CAP_CYC3[23:0];
        3'h4: base = CAP_CYC4[23:0];
        3'h5: base = CAP_CYC5[23:0];
        3'h6: base = CAP_CYC6[23:0];
        default: base = CAP_CYC7[23:0];
      endcase
      capCycles = scaleTime(base, halve);
    end
  endfunction

  reg [7:0] config_q;
  reg [7:0] config_d;
  reg [7:0] excSetup_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [23:0] count_q;
  reg [23:0] count_d;
  reg capDone_d;
  reg vtDone_d;
  reg modeEnd;
  reg [31:0] readMux;
  reg addrOk;

  wire [1:0] vtFilter = config_q[`CRC_VTF_HI:`CRC_VTF_LO];
  wire [2:0] capFilter = config_q[`CRC_CAPF_HI:`CRC_CAPF_LO];
  wire [2:0] convMode = config_q[`CRC_MODE_HI:`CRC_MODE_LO];
  wire clockHalve = excSetup_q[`CRC_CLK_HALVE];
  wire [23:0] capTime = capCycles(capFilter, clockHalve);
  wire [23:0] vtTime = vtCycles(vtFilter, clockHalve);

  wire runMode = modeRuns(convMode);
  wire calMode = modeCalibrates(convMode);
  // A write lands only at the edge that completes the access phase
  wire access = psel && penable && pready;
  wire accessFirst = psel && penable && !pready;
  wire wrConfig = access && pwrite && regHit(paddr, `CRC_ADDR_CONFIG);
  wire wrExc = access && pwrite && regHit(paddr, `CRC_ADDR_EXC);
  // The counter starts at the full count, so the last cycle is the one at count one
  wire lastCycle = (count_q == 24'h000001);

  // Address decode and read data
  always @* begin
    addrOk = 1'b1;
    readMux = 32'h00000000;
    case (paddr)
      `CRC_ADDR_CONFIG: readMux = {24'h000000, config_q};
      `CRC_ADDR_EXC: readMux = {24'h000000, excSetup_q};
      `CRC_ADDR_STATUS: readMux = {28'h0000000, 1'b0, vtConverting, capConverting, runMode};
      `CRC_ADDR_CAPTIME: readMux = {8'h00, capTime};
      `CRC_ADDR_VTTIME: readMux = {8'h00, vtTime};
      default: addrOk = 1'b0;
    endcase
  end

  // Conversion sequencer: capacitance then voltage/temperature, repeated in continuous mode
  always @* begin
    state_d = state_q;
    count_d = count_q;
    modeEnd = 1'b0;
    capDone_d = 1'b0;
    vtDone_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (runMode || calMode) begin
          state_d = ST_CAP;
          count_d = capTime;
        end
      end
      ST_CAP: begin
        if (!(runMode || calMode)) begin
          state_d = ST_IDLE;
          count_d = 24'h000000;
        end else if (lastCycle) begin
          capDone_d = 1'b1;
          if (calMode) begin
            // Calibration takes one capacitance conversion and then falls back to idle
            state_d = ST_IDLE;
            modeEnd = 1'b1;
          end else begin
            state_d = ST_VT;
            count_d = vtTime;
          end
        end else begin
          count_d = count_q - 24'h000001;
        end
      end
      ST_VT: begin
        if (!runMode) begin
          state_d = ST_IDLE;
          count_d = 24'h000000;
        end else if (lastCycle) begin
          vtDone_d = 1'b1;
          if (convMode == `CRC_MODE_SINGLE) begin
            state_d = ST_IDLE;
            modeEnd = 1'b1;
          end else begin
            state_d = ST_CAP;
            count_d = capTime;
          end
        end else begin
          count_d = count_q - 24'h000001;
        end
      end
      default: begin
        state_d = ST_IDLE;
        count_d = 24'h000000;
      end
    endcase
  end

  // Config next value: a software write wins over the sequencer returning the mode to idle
  always @* begin
    config_d = config_q;
    if (wrConfig) begin
      config_d = pwdata[7:0];
    end else if (modeEnd) begin
      config_d = withModeIdle(config_q);
    end
  end

  // Software registers
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      config_q <= `CRC_CONFIG_RST;
      excSetup_q <= `CRC_EXC_RST;
    end else begin
      config_q <= config_d;
      if (wrExc) begin
        excSetup_q <= pwdata[7:0];
      end
    end
  end

  // Sequencer state and conversion counter
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      count_q <= 24'h000000;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  // APB response: one wait state, pready rises in the second access cycle
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= accessFirst;
      pslverr <= accessFirst && !addrOk;
      // Read data is captured a cycle ahead so that it leaves a flip-flop together with pready
      if (accessFirst && !pwrite) begin
        prdata <= readMux;
      end
    end
  end

  // Conversion status and timing outputs
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      capConverting <= 1'b0;
      vtConverting <= 1'b0;
      capDone <= 1'b0;
      vtDone <= 1'b0;
      capConvCycles <= 24'h000000;
      vtConvCycles <= 24'h000000;
    end else begin
      capConverting <= (state_d == ST_CAP);
      vtConverting <= (state_d == ST_VT);
      capDone <= capDone_d;
      vtDone <= vtDone_d;
      capConvCycles <= capTime;
      vtConvCycles <= vtTime;
    end
  end

endmodule

// file: crc_conv_props.sv
// Checker for APB handshake and conversion pulses of the rate config block
module crc_conv_props (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // APB
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // Conversion
  input wire capConverting,
  input wire vtConverting,
  input wire capDone,
  input wire vtDone
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_ready_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("no single wait state");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready long");
  a_err_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
  a_cap_done: assert property (capDone |-> $past(capConverting)) else $error("stray cap");
  a_vt_done: assert property (vtDone |-> $past(vtConverting)) else $error("stray vt");
  a_cap_pulse: assert property (capDone |=> !capDone) else $error("capDone long");
  a_vt_pulse: assert property (vtDone |=> !vtDone) else $error("vtDone long");
  a_one_chan: assert property (!(capConverting && vtConverting)) else $error("both busy");
  c_cap: cover property (capDone);
  c_vt: cover property (vtDone);
  c_err: cover property (pslverr);
endmodule

bind crc_conversion_rate_config crc_conv_props u_props (.sys_clk, .reset_n, .psel, .penable,
  .pready, .pslverr, .capConverting, .vtConverting, .capDone, .vtDone);

// file: crc_conversion_rate_config_tb.sv
// Self-checking bench for the rate config block
module crc_conversion_rate_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sysClk = 0;
  logic resetN = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, perr, capConverting, vtConverting, capDone, vtDone;
  logic [23:0] capConvCycles, vtConvCycles;
  logic [7:0] cfg;
  int miscompares = 0;
  int checks = 0;
  // Table model in cycles, 25 per microsecond; only the codes timed below are shortened
  int vtT[4] = '{10, 12, 62100 * 25, 122100 * 25};
  int capT[8] = '{20, 11900 * 25, 20000 * 25, 26, 62000 * 25, 77000 * 25, 92000 * 25,
    109600 * 25};
  always #20 sysClk = ~sysClk;
  crc_conversion_rate_config #(.VT_CYC0(10), .VT_CYC1(12), .CAP_CYC0(20),
    .CAP_CYC3(26)) dut (.sys_clk(sysClk), .reset_n(resetN),
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .capConverting,
    .vtConverting, .capDone, .vtDone, .capConvCycles, .vtConvCycles);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Entered just after a rising edge; ends one edge after release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sysClk);
    penable <= 1;
    do @(posedge sysClk); while (pready !== 1'b1 && ++t < 20);
    chk(pready, 1);
    rd = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sysClk);
  endtask
  // Done pulse timing is checked with two cycles of slack
  task automatic waitDone(input bit vt, input int exp);
    int t;
    t = 0;
    while ((vt ? vtDone : capDone) !== 1'b1 && t < 1000) begin
      @(posedge sysClk);
      t++;
    end
    chk(t >= exp - 2 && t <= exp + 2, 1);
  endtask
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    test_done();
  end
  initial begin
    void'($urandom(32'h9a07));
    repeat (4) @(posedge sysClk);
    resetN <= 1;
    @(posedge sysClk);
    apb(0, 8'h00, 0);
    chk(rd, 32'ha0);
    chk(capConvCycles, capT[4]);
    chk(vtConvCycles, vtT[2]);
    $display("reset test done");
    for (int i = 0; i < 64; i++) begin
      cfg = {i[1:0], i[4:2], 3'h0};
      apb(1, 8'h04, {24'h0, i[5], 7'($urandom)});
      apb(1, 8'h00, {24'h0, cfg});
      apb(0, 8'h00, 0);
      chk(rd, cfg);
      apb(0, 8'h0c, 0);
      chk(rd, capT[i[4:2]] << i[5]);
      chk(capConvCycles, capT[i[4:2]] << i[5]);
      chk(vtConvCycles, vtT[i[1:0]] << i[5]);
    end
    $display("table test done");
    apb(1, 8'h04, 32'h80);
    apb(1, 8'h00, 32'h5a);
    waitDone(0, 2 * capT[3]);
    waitDone(1, 2 * vtT[1]);
    repeat (2) @(posedge sysClk);
    apb(0, 8'h00, 0);
    chk(rd, 32'h58);
    $display("single test done");
    apb(1, 8'h04, 32'h00);
    apb(1, 8'h00, 32'h01);
    waitDone(0, capT[0]);
    waitDone(1, vtT[0]);
    waitDone(0, capT[0]);
    apb(0, 8'h08, 0);
    chk(rd, 32'h5);
    apb(1, 8'h00, 32'h00);
    repeat (3) @(posedge sysClk);
    chk(capConverting | vtConverting, 0);
    $display("continuous test done");
    apb(1, 8'h00, 32'h05);
    waitDone(0, capT[0]);
    repeat (2) @(posedge sysClk);
    chk(vtConverting, 0);
    apb(0, 8'h00, 0);
    chk(rd, 32'h00);
    $display("calibration test done");
    apb(1, 8'h0c, 32'h1234);
    apb(0, 8'h0c, 0);
    chk(rd, capT[0]);
    apb(0, 8'h20, 0);
    chk(perr, 1);
    chk(rd, 0);
    $display("access test done");
    test_done();
  end
endmodule
